// ### rtl/quad_dac_command_decoder.sv
`timescale 1ns/1ps
// Summary of operation
// - write-all command writes codes, loads every modified channel
// - unmodified code registers skip output load
// - write-selected command writes, loads addressed channels
// - load without writing uses transfer command
// - multibyte flag accepted like other writes
// - power command changes masked channels only
// - mode 00 normal, 01 1k, 10 100k
// - mask bit three D down to A
// - all channels down means standby
// - powered-down output disconnected, pulled down or open
// - output registers kept in standby
// - commands still decoded while powered down
// - clear select zero zeroes codes, outputs
// - clear select one restores all defaults
// - address 0-3 one channel, 1xx all
// - transparent latch drives output from code
// - reference off in standby unless kept on
module quad_dac_command_decoder (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	output logic [47:0] dac_code,
	output logic [3:0] buffer_enable,
	output logic [3:0] pull_down_1k,
	output logic [3:0] pull_down_100k,
	output logic standby,
	output logic reference_on,
	output logic [1:0] reference_mode
);

	logic command_strobe;
	logic [23:0] command_data;
	logic [23:0] last_command;
	logic [23:0] next_last_command;
	logic [3:0] latch_transparent;
	logic [3:0] next_latch_transparent;
	logic [1:0] ref_mode;
	logic [1:0] next_ref_mode;
	logic ref_keep_on;
	logic next_ref_keep_on;
	dac_cmd_pkg::opcode_type opcode;
	logic [3:0] addressed;
	logic [11:0] code_value;
	logic [3:0] write_code;
	logic [3:0] transfer;
	logic [3:0] transfer_if_modified;
	logic zero_codes;
	logic restore_defaults;
	logic [3:0] power_write;
	logic [1:0] power_mode_value;
	logic [11:0] code_reg [4];
	logic [11:0] out_reg [4];
	logic [1:0] power_mode [4];
	logic [3:0] modified;
	logic [127:0] channel_words;
	logic [31:0] status_word;
	logic [7:0] power_modes_packed;
	logic multibyte;

	// channel address to one-hot mask, 1xx selects all
	function automatic logic [3:0] channel_mask(input logic [2:0] addr);
		if (addr[2]) begin
			channel_mask = 4'hF;
		end else begin
			channel_mask = 4'h1 << addr[1:0];
		end
	endfunction

	apb_register_port u_apb (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pready(pready),
		.pslverr(pslverr),
		.prdata(prdata),
		.status_word(status_word),
		.command_word({8'h00, last_command}),
		.channel_words(channel_words),
		.command_strobe(command_strobe),
		.command_data(command_data)
	);

	// command decode; runs in any power state
	always_comb begin
		opcode = dac_cmd_pkg::opcode_type'(command_data[dac_cmd_pkg::OPCODE_LSB +: 3]);
		// multibyte frames carry the same fields, so the flag needs no separate path
		multibyte = command_data[dac_cmd_pkg::MULTIBYTE_BIT];
		addressed = channel_mask(command_data[dac_cmd_pkg::CHANNEL_ADDR_LSB +: 3]);
		code_value = command_data[dac_cmd_pkg::CODE_LSB +: 12];
		power_mode_value = command_data[dac_cmd_pkg::PD_MODE_LSB +: 2];
		write_code = 4'h0;
		transfer = 4'h0;
		transfer_if_modified = 4'h0;
		zero_codes = 1'b0;
		restore_defaults = 1'b0;
		power_write = 4'h0;
		next_last_command = last_command;
		next_latch_transparent = latch_transparent;
		next_ref_mode = ref_mode;
		next_ref_keep_on = ref_keep_on;
		if (command_strobe) begin
			next_last_command = command_data;
			unique case (opcode)
				dac_cmd_pkg::OP_WRITE_CODE_ONLY: begin
					write_code = addressed;
				end
				dac_cmd_pkg::OP_TRANSFER_CODE_SELECTED: begin
					transfer = addressed;
				end
				dac_cmd_pkg::OP_WRITE_CODE_UPDATE_ALL: begin
					write_code = addressed;
					transfer_if_modified = 4'hF;
				end
				dac_cmd_pkg::OP_WRITE_CODE_UPDATE_SELECTED: begin
					write_code = addressed;
					transfer_if_modified = addressed;
				end
				dac_cmd_pkg::OP_POWER: begin
					power_write = command_data[dac_cmd_pkg::SELECT_MASK_LSB +: 4];
				end
				dac_cmd_pkg::OP_SOFT_CLEAR_OR_RESTORE: begin
					if (command_data[dac_cmd_pkg::CLEAR_SELECT_BIT]) begin
						restore_defaults = 1'b1;
						next_latch_transparent = dac_cmd_pkg::LATCH_RESET;
						next_ref_mode = dac_cmd_pkg::REF_MODE_RESET;
						next_ref_keep_on = dac_cmd_pkg::REF_KEEP_ON_RESET;
					end else begin
						zero_codes = 1'b1;
					end
				end
				dac_cmd_pkg::OP_CONFIG: begin
					next_latch_transparent = command_data[dac_cmd_pkg::LATCH_MASK_LSB +: 4];
				end
				dac_cmd_pkg::OP_REFERENCE: begin
					next_ref_mode = command_data[dac_cmd_pkg::REF_MODE_LSB +: 2];
					next_ref_keep_on = command_data[dac_cmd_pkg::REF_KEEP_ON_BIT];
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_command <= dac_cmd_pkg::COMMAND_RESET;
			latch_transparent <= dac_cmd_pkg::LATCH_RESET;
			ref_mode <= dac_cmd_pkg::REF_MODE_RESET;
			ref_keep_on <= dac_cmd_pkg::REF_KEEP_ON_RESET;
		end else if (ce) begin
			last_command <= next_last_command;
			latch_transparent <= next_latch_transparent;
			ref_mode <= next_ref_mode;
			ref_keep_on <= next_ref_keep_on;
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < dac_cmd_pkg::CHANNELS; ch++) begin : g_channel
			dac_channel u_channel (
				.pclk(pclk),
				.presetn(presetn),
				.ce(ce),
				.write_code(write_code[ch]),
				.transfer(transfer[ch]),
				.transfer_if_modified(transfer_if_modified[ch]),
				.code_in(code_value),
				.zero_codes(zero_codes),
				.restore_defaults(restore_defaults),
				.power_write(power_write[ch]),
				.power_mode_in(power_mode_value),
				.transparent(latch_transparent[ch]),
				.code_reg(code_reg[ch]),
				.out_reg(out_reg[ch]),
				.dac_code(dac_code[ch * 12 +: 12]),
				.power_mode(power_mode[ch]),
				.modified(modified[ch])
			);
			// powered-down output leaves the buffer, takes the chosen load
			assign buffer_enable[ch] = (power_mode[ch] == dac_cmd_pkg::PM_NORMAL);
			assign pull_down_1k[ch] = (power_mode[ch] == dac_cmd_pkg::PM_PULL_1K);
			assign pull_down_100k[ch] = (power_mode[ch] == dac_cmd_pkg::PM_PULL_100K);
			assign power_modes_packed[ch * 2 +: 2] = power_mode[ch];
			assign channel_words[ch * 32 +: 32] = {modified[ch], 1'b0, power_mode[ch], out_reg[ch],
				4'h0, code_reg[ch]};
		end
	endgenerate

	assign standby = ~|buffer_enable;
	assign reference_on = (ref_mode != dac_cmd_pkg::REF_MODE_RESET) & (~standby | ref_keep_on);
	assign reference_mode = ref_mode;

	assign status_word = {8'h00, power_modes_packed, 7'h00, reference_on, standby, ref_keep_on,
		ref_mode, latch_transparent};

endmodule // quad_dac_command_decoder

// ### rtl/dac_cmd_pkg.sv
package dac_cmd_pkg;

	localparam int CODE_WIDTH = 12;
	localparam int CHANNELS = 4;
	localparam int APB_ADDR_WIDTH = 12;

	// register byte offsets
	localparam logic [11:0] ADDR_COMMAND = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_CHANNEL_BASE = 12'h010;
	localparam logic [11:0] ADDR_CHANNEL_STEP = 12'h004;

	// command word fields
	localparam int CMD_WIDTH = 24;
	localparam int MULTIBYTE_BIT = 22;
	localparam int OPCODE_LSB = 19;
	localparam int CHANNEL_ADDR_LSB = 16;
	localparam int CHANNEL_ADDR_ALL_BIT = 18;
	localparam int CODE_LSB = 4;
	localparam int PD_MODE_LSB = 4;
	localparam int SELECT_MASK_LSB = 0;
	localparam int CLEAR_SELECT_BIT = 0;
	localparam int LATCH_MASK_LSB = 0;
	localparam int REF_MODE_LSB = 0;
	localparam int REF_KEEP_ON_BIT = 2;

	// status word fields
	localparam int STAT_LATCH_LSB = 0;
	localparam int STAT_REF_MODE_LSB = 4;
	localparam int STAT_KEEP_ON_BIT = 6;
	localparam int STAT_STANDBY_BIT = 7;
	localparam int STAT_REF_ON_BIT = 8;
	localparam int STAT_PD_MODE_LSB = 16;

	// channel word fields
	localparam int CHW_CODE_LSB = 0;
	localparam int CHW_OUT_LSB = 16;
	localparam int CHW_PD_LSB = 28;
	localparam int CHW_MODIFIED_BIT = 31;

	// values after reset
	localparam logic [11:0] CODE_RESET = 12'h000;
	localparam logic [3:0] LATCH_RESET = 4'h0;
	localparam logic [1:0] REF_MODE_RESET = 2'h0;
	localparam logic REF_KEEP_ON_RESET = 1'b0;
	localparam logic [23:0] COMMAND_RESET = 24'h000000;

	typedef enum logic [2:0] {
		OP_WRITE_CODE_ONLY = 3'h0,
		OP_TRANSFER_CODE_SELECTED = 3'h1,
		OP_WRITE_CODE_UPDATE_ALL = 3'h2,
		OP_WRITE_CODE_UPDATE_SELECTED = 3'h3,
		OP_POWER = 3'h4,
		OP_SOFT_CLEAR_OR_RESTORE = 3'h5,
		OP_CONFIG = 3'h6,
		OP_REFERENCE = 3'h7
	} opcode_type;

	typedef enum logic [1:0] {
		PM_NORMAL = 2'h0,
		PM_PULL_1K = 2'h1,
		PM_PULL_100K = 2'h2,
		PM_HIGH_Z = 2'h3
	} power_mode_type;

	localparam logic [1:0] PD_MODE_RESET = 2'h0;

endpackage

// ### rtl/dac_channel.sv
`timescale 1ns/1ps
module dac_channel (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic write_code,
	input wire logic transfer,
	input wire logic transfer_if_modified,
	input wire logic [11:0] code_in,
	input wire logic zero_codes,
	input wire logic restore_defaults,
	input wire logic power_write,
	input wire logic [1:0] power_mode_in,
	input wire logic transparent,
	output logic [11:0] code_reg,
	output logic [11:0] out_reg,
	output logic [11:0] dac_code,
	output logic [1:0] power_mode,
	output logic modified
);

	logic [11:0] next_code_reg;
	logic [11:0] next_out_reg;
	logic [1:0] next_power_mode;
	logic next_modified;
	logic do_transfer;

	always_comb begin
		next_code_reg = code_reg;
		next_out_reg = out_reg;
		next_power_mode = power_mode;
		next_modified = modified;
		// unchanged codes are not reloaded
		do_transfer = transfer | (transfer_if_modified & (modified | write_code));
		if (zero_codes || restore_defaults) begin
			next_code_reg = dac_cmd_pkg::CODE_RESET;
			next_out_reg = dac_cmd_pkg::CODE_RESET;
			next_modified = 1'b0;
			if (restore_defaults) begin
				next_power_mode = dac_cmd_pkg::PD_MODE_RESET;
			end
		end else begin
			if (write_code) begin
				next_code_reg = code_in;
				next_modified = 1'b1;
			end
			if (do_transfer) begin
				next_out_reg = write_code ? code_in : code_reg;
				next_modified = 1'b0;
			end
		end
		if (power_write) begin
			next_power_mode = power_mode_in;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			code_reg <= dac_cmd_pkg::CODE_RESET;
			out_reg <= dac_cmd_pkg::CODE_RESET;
			power_mode <= dac_cmd_pkg::PD_MODE_RESET;
			modified <= 1'b0;
		end else if (ce) begin
			code_reg <= next_code_reg;
			out_reg <= next_out_reg;
			power_mode <= next_power_mode;
			modified <= next_modified;
		end
	end

	// output register kept through power-down and standby
	assign dac_code = transparent ? code_reg : out_reg;

endmodule // dac_channel

// ### rtl/apb_register_port.sv
`timescale 1ns/1ps
module apb_register_port (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	input wire logic [31:0] status_word,
	input wire logic [31:0] command_word,
	input wire logic [127:0] channel_words,
	output logic command_strobe,
	output logic [23:0] command_data
);

	logic [31:0] next_prdata;
	logic next_error;
	logic error;
	logic [11:0] channel_offset;

	function automatic logic mapped(input logic [11:0] addr, input logic is_write);
		logic is_channel;
		is_channel = (addr >= dac_cmd_pkg::ADDR_CHANNEL_BASE) &&
			(addr < dac_cmd_pkg::ADDR_CHANNEL_BASE + 12'h010) && (addr[1:0] == 2'h0);
		if (is_write) begin
			mapped = (addr == dac_cmd_pkg::ADDR_COMMAND);
		end else begin
			mapped = (addr == dac_cmd_pkg::ADDR_COMMAND) || (addr == dac_cmd_pkg::ADDR_STATUS) || is_channel;
		end
	endfunction

	always_comb begin
		next_prdata = prdata;
		next_error = error;
		channel_offset = paddr - dac_cmd_pkg::ADDR_CHANNEL_BASE;
		if (psel && !penable) begin
			next_error = !mapped(paddr, pwrite);
			next_prdata = 32'h00000000;
			if (!pwrite && mapped(paddr, 1'b0)) begin
				if (paddr == dac_cmd_pkg::ADDR_COMMAND) begin
					next_prdata = command_word;
				end else if (paddr == dac_cmd_pkg::ADDR_STATUS) begin
					next_prdata = status_word;
				end else begin
					next_prdata = channel_words[channel_offset[3:2] * 32 +: 32];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			error <= 1'b0;
		end else if (ce) begin
			prdata <= next_prdata;
			error <= next_error;
		end
	end

	assign pready = 1'b1;
	assign pslverr = psel & penable & error;
	// a command runs at the access edge of a mapped write
	assign command_strobe = ce & psel & penable & pwrite & !error;
	assign command_data = pwdata[23:0];

endmodule // apb_register_port

// ### bench/dac_cmd_monitor.sv
`timescale 1ns/1ps
module dac_cmd_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [47:0] dac_code,
	input wire logic [3:0] buffer_enable,
	input wire logic [3:0] pull_down_1k,
	input wire logic [3:0] pull_down_100k,
	input wire logic standby,
	input wire logic reference_on,
	input wire logic [1:0] reference_mode
);
	logic cw;
	logic pw;
	assign cw = psel && penable && pwrite && ce && paddr == 12'h000;
	assign pw = cw && pwdata[21:19] == 3'h4;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	standby_all_down_a: assert property (standby == (buffer_enable == 4'h0)) else $error("standby wrong");
	mode_exclusive_a: assert property (((buffer_enable & pull_down_1k) | (buffer_enable & pull_down_100k)
		| (pull_down_1k & pull_down_100k)) == 4'h0) else $error("two output modes");
	ref_awake_a: assert property (!standby |-> reference_on == (reference_mode != 2'h0)) else $error("ref wrong");
	mask_only_a: assert property (pw |=> ((buffer_enable ^ $past(buffer_enable)) & ~$past(pwdata[3:0])) == 4'h0)
		else $error("unmasked channel changed");
	buffer_decode_a: assert property (pw |=> (buffer_enable & $past(pwdata[3:0]))
		== ($past(pwdata[5:4]) == 2'h0 ? $past(pwdata[3:0]) : 4'h0)) else $error("buffer mode wrong");
	pull_decode_a: assert property (pw |=> (pull_down_100k & $past(pwdata[3:0]))
		== ($past(pwdata[5:4]) == 2'h2 ? $past(pwdata[3:0]) : 4'h0)) else $error("pull mode wrong");
	code_load_a: assert property (cw && pwdata[21:20] == 2'h1 && !pwdata[18]
		|=> dac_code[12*$past(pwdata[17:16]) +: 12] == $past(pwdata[15:4])) else $error("code not loaded");
	load_every_a: assert property (cw && pwdata[21:19] == 3'h3 && pwdata[18]
		|=> dac_code == {4{$past(pwdata[15:4])}}) else $error("all load wrong");
	zero_clear_a: assert property (cw && pwdata[21:19] == 3'h5 |=> dac_code == 48'h0) else $error("not zeroed");
	defaults_restore_a: assert property (cw && pwdata[21:19] == 3'h5 && pwdata[0]
		|=> buffer_enable == 4'hF && reference_mode == 2'h0) else $error("not restored");
	idle_hold_a: assert property (!cw |=> $stable(dac_code) && $stable(buffer_enable)) else $error("drift");
endmodule // dac_cmd_monitor
bind quad_dac_command_decoder dac_cmd_monitor mon (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
	.pwdata, .dac_code, .buffer_enable, .pull_down_1k, .pull_down_100k, .standby, .reference_on, .reference_mode);

// ### bench/dac_host_model.sv
`timescale 1ns/1ps
module dac_host_model (
	input wire logic pclk,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
	end
	// one apb transfer, held until pready is sampled high
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule // dac_host_model

// ### bench/quad_dac_command_decoder_bench.sv
`timescale 1ns/1ps
module quad_dac_command_decoder_bench;
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, standby, reference_on, e;
	logic [11:0] paddr, c;
	logic [31:0] pwdata, prdata, r;
	logic [47:0] dac_code;
	logic [3:0] buffer_enable, pull_down_1k, pull_down_100k;
	logic [1:0] reference_mode;
	logic [11:0] v [4];
	int failures, check_count, seed, i;
	quad_dac_command_decoder DUT (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.pslverr, .prdata, .dac_code, .buffer_enable, .pull_down_1k, .pull_down_100k, .standby, .reference_on,
		.reference_mode);
	dac_host_model host (.pclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	function automatic logic [11:0] ch(input int n);
		return dac_code[12*n +: 12];
	endfunction
	function automatic logic [31:0] chan_word(input logic m, input logic [1:0] pm, input logic [11:0] o,
		input logic [11:0] cd);
		return {m, 1'b0, pm, o, 4'h0, cd};
	endfunction
	task automatic chk(input string n, input logic [63:0] s, input logic [63:0] x);
		check_count++;
		if (s !== x) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic cmd(input logic [2:0] op, input logic [2:0] a, input logic [15:0] d);
		host.xfer(1'b1, 12'h000, {8'hA5, 1'b0, 1'($random(seed)), op, a, d}, r, e);
		#1;
	endtask
	task automatic wrap_up;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#50000;
		failures++;
		wrap_up;
	end
	initial begin
		seed = 84;
		presetn = 1'b0;
		ce = 1'b1;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		chk("reset code", dac_code, 48'h0);
		chk("reset buffers", buffer_enable, 4'hF);
		host.xfer(1'b0, 12'h0FC, 32'h0, r, e);
		chk("unmapped read", {e, r}, 33'h100000000);
		for (i = 0; i < 4; i++) begin
			v[i] = 12'($random(seed));
			cmd(3'h3, 3'(i), {v[i], 4'hA});
			chk("write selected", ch(i), v[i]);
		end
		c = 12'($random(seed));
		cmd(3'h0, 3'h0, {c, 4'h0});
		chk("no direct drive", ch(0), v[0]);
		host.xfer(1'b0, 12'h010, 32'h0, r, e);
		chk("pending word", r, chan_word(1'b1, 2'h0, v[0], c));
		v[0] = c;
		v[1] = 12'($random(seed));
		cmd(3'h2, 3'h1, {v[1], 4'h0});
		for (i = 0; i < 4; i++) chk("load all", ch(i), v[i]);
		host.xfer(1'b0, 12'h010, 32'h0, r, e);
		chk("loaded word", r, chan_word(1'b0, 2'h0, v[0], v[0]));
		host.xfer(1'b0, 12'h018, 32'h0, r, e);
		chk("modified flag", r[31], 1'b0);
		for (i = 0; i < 4; i++) begin
			v[i] = 12'($random(seed));
			cmd(3'h0, 3'(i), {v[i], 4'h0});
		end
		cmd(3'h1, 3'h5, 16'hFFFF);
		for (i = 0; i < 4; i++) chk("transfer all", ch(i), v[i]);
		c = 12'($random(seed));
		cmd(3'h3, 3'h6, {c, 4'h0});
		chk("write every", dac_code, {4{c}});
		ce <= 1'b0;
		cmd(3'h3, 3'h4, {~c, 4'h0});
		ce <= 1'b1;
		chk("frozen", dac_code, {4{c}});
		cmd(3'h7, 3'h0, 16'h0001);
		for (i = 1; i < 4; i++) cmd(3'h4, 3'h7, {10'h3FF, 2'(i), 4'(1 << (i - 1))});
		chk("1k pulls", pull_down_1k, 4'h1);
		chk("100k pulls", pull_down_100k, 4'h2);
		chk("buffers", buffer_enable, 4'h8);
		cmd(3'h4, 3'h0, 16'h0018);
		chk("standby", {standby, reference_on}, 2'h2);
		chk("kept output", ch(3), c);
		host.xfer(1'b0, 12'h004, 32'h0, r, e);
		chk("status word", r, 32'h00790090);
		v[2] = 12'($random(seed));
		cmd(3'h3, 3'h2, {v[2], 4'h0});
		chk("decode in standby", ch(2), v[2]);
		cmd(3'h7, 3'h0, 16'h0005);
		chk("ref kept on", reference_on, 1'b1);
		cmd(3'h4, 3'h0, 16'h0001);
		chk("wake", {standby, buffer_enable}, 5'h01);
		cmd(3'h6, 3'h0, 16'h0001);
		c = 12'($random(seed));
		cmd(3'h0, 3'h0, {c, 4'h0});
		chk("transparent", ch(0), c);
		cmd(3'h5, 3'h0, 16'hFFFE);
		chk("clear", {buffer_enable, dac_code}, {4'h1, 48'h0});
		cmd(3'h5, 3'h0, 16'h0001);
		chk("restore", {buffer_enable, reference_mode, reference_on}, 7'h78);
		cmd(3'h0, 3'h0, {c, 4'h0});
		chk("latch restored", ch(0), 12'h000);
		cmd(3'h3, 3'h4, {12'hFFF, 4'h0});
		chk("load before reset", dac_code, {4{12'hFFF}});
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		chk("mid reset", {buffer_enable, standby, dac_code}, {4'hF, 1'b0, 48'h0});
		host.xfer(1'b1, 12'h004, 32'hFFFFFFFF, r, e);
		chk("refused write", e, 1'b1);
		wrap_up;
	end
endmodule // quad_dac_command_decoder_bench
